// ==== pkg/apb_defines.svh ====
// constants for the asynchronous peripheral access bridge
`ifndef APB_DEFINES_SVH
`define APB_DEFINES_SVH
`define APB_SYNC_STAGES 2
`define APB_ADDR_W 23
`define APB_DATA_W 8
`define APB_RESET_STAGE 1'b0
`endif

// ==== pkg/apb_pkg.sv ====
// types for the asynchronous peripheral access bridge
package apb_pkg;
  // processor-side strobes as sampled (active high after inversion)
  typedef struct packed {
    logic as;
    logic uds;
    logic lds;
    logic rd;
  } apb_strobe_t;
  // latch steering toward the data pins
  typedef struct packed {
    logic rd_oe;
    logic wr_oe;
    logic capture;
  } apb_latch_ctl_t;
  typedef enum logic [1:0] {APB_IDLE, APB_SELECT, APB_ACK} apb_state_t;
endpackage

// ==== hdl/apb_sync.sv ====
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module apb_sync #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign o_sync = sync_q;
endmodule
`default_nettype wire

// ==== hdl/apb_latch.sv ====
// byte latch: captures on a strobe, holds; output always driven, no enable
`timescale 1ns/1ps
`default_nettype none
module apb_latch #(
  parameter int W = 8
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_capture,
  input  wire logic         i_hold,
  output logic      [W-1:0] o_data
);
  logic [W-1:0] data_q;
  logic [W-1:0] data_d;
  always_comb begin
    // transparent while not holding, frozen once captured
    data_d = data_q;
    if (i_capture || !i_hold) begin
      data_d = i_data;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      data_q <= '0;
    end else begin
      data_q <= data_d;
    end
  end
  assign o_data = data_q;
endmodule
`default_nettype wire

// ==== hdl/apb_bridge.sv ====
// bridge from an asynchronous 16-bit processor bus to an 8-bit e-clocked peripheral
`timescale 1ns/1ps
`default_nettype none
`include "apb_defines.svh"
module apb_bridge import apb_pkg::*; #(
  parameter int AW = `APB_ADDR_W,
  parameter int DW = `APB_DATA_W,
  parameter logic [AW-1:0] BASE = 23'h7F_0000,
  parameter logic [AW-1:0] MASK = 23'h7F_FF00
) (
  // clock and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  // processor bus, active low strobes
  input  wire logic          i_as_n,
  input  wire logic          i_uds_n,
  input  wire logic          i_lds_n,
  input  wire logic          i_rw,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_cpu_data,
  output logic      [DW-1:0] o_cpu_data,
  output logic               o_cpu_data_oe,
  output logic               o_dtack_n,
  output logic               o_dtack_oe,
  // peripheral side
  input  wire logic          i_e_clk,
  input  wire logic [DW-1:0] i_per_data,
  output logic      [DW-1:0] o_per_data,
  output logic               o_per_data_oe,
  output logic               o_peripheral_chip_select_n
);
  // ****************************************
  // input synchronisers
  // ****************************************
  // all pins are asynchronous to the reference clock, e included
  logic [4:0]  raw_s;
  logic [4:0]  syn_s;
  logic [AW:0] abus_raw;
  logic [AW:0] abus_syn;
  apb_strobe_t stb;
  logic        e_syn;
  logic        e_prev_q;
  logic        e_prev_d;
  logic        e_fall;
  assign raw_s = {~i_as_n, ~i_uds_n, ~i_lds_n, i_rw, i_e_clk};
  assign abus_raw = {i_rw, i_addr};
  apb_sync #(.W(5)) u_sync_ctl (
    .i_ref_clk(i_ref_clk),
    .i_rst    (i_rst),
    .i_async  (raw_s),
    .o_sync   (syn_s)
  );
  // address is stable by the time the synchronised strobes arrive
  apb_sync #(.W(AW + 1)) u_sync_addr (
    .i_ref_clk(i_ref_clk),
    .i_rst    (i_rst),
    .i_async  (abus_raw),
    .o_sync   (abus_syn)
  );
  assign stb = apb_strobe_t'(syn_s[4:1]);
  assign e_syn = syn_s[0];
  assign e_fall = e_prev_q && !e_syn;
  // ****************************************
  // decode
  // ****************************************
  logic peripheral_decode_select;
  logic ds_any;
  assign ds_any = stb.uds || stb.lds;
  // internal select only; the pin is driven by the timed stage
  assign peripheral_decode_select = stb.as && ((abus_syn[AW-1:0] & MASK) == BASE);
  // ****************************************
  // timing stages
  // ****************************************
  apb_state_t     state_q;
  apb_state_t     state_d;
  apb_latch_ctl_t lat_q;
  apb_latch_ctl_t lat_d;
  logic           select_timing_stage;
  logic           ack_timing_stage;
  logic           cs_n_q;
  logic           cs_n_d;
  logic           dtack_oe_q;
  logic           dtack_oe_d;
  logic           read_acc;
  assign read_acc = peripheral_decode_select && abus_syn[AW];
  assign select_timing_stage = (state_q == APB_SELECT);
  assign ack_timing_stage = (state_q == APB_ACK);
  // e edge detect; reset level equals the synchroniser's, so no false fall
  always_comb begin
    e_prev_d = e_syn;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      e_prev_q <= 1'b0;
    end else begin
      e_prev_q <= e_prev_d;
    end
  end
  // latch steering follows the decoded direction one cycle late
  always_comb begin
    lat_d = '{rd_oe: 1'b0, wr_oe: 1'b1, capture: 1'b0};
    if (read_acc) begin
      lat_d.rd_oe = 1'b1;
      lat_d.wr_oe = 1'b0;
    end
    // capture on the edge that moves the select stage into acknowledge
    lat_d.capture = select_timing_stage && ds_any && e_fall;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lat_q <= '{rd_oe: 1'b0, wr_oe: 1'b1, capture: 1'b0};
    end else begin
      lat_q <= lat_d;
    end
  end
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      APB_IDLE: begin
        if (peripheral_decode_select && ds_any && e_fall) begin
          state_d = APB_SELECT;
        end
      end
      APB_SELECT: begin
        if (!ds_any) begin
          state_d = APB_IDLE;
        end else if (e_fall) begin
          state_d = APB_ACK;
        end
      end
      APB_ACK: begin
        if (!ds_any) begin
          state_d = APB_IDLE;
        end
      end
      // two state bits leave one code unused; fall back to idle
      default: begin
        state_d = APB_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q <= APB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end
  // pins from their own flops: no decode glitch reaches the peripheral
  always_comb begin
    // chip select only in the select stage; acknowledge drops it at once
    cs_n_d = !(state_d == APB_SELECT);
    dtack_oe_d = (state_d == APB_ACK);
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cs_n_q     <= 1'b1;
      dtack_oe_q <= 1'b0;
    end else begin
      cs_n_q     <= cs_n_d;
      dtack_oe_q <= dtack_oe_d;
    end
  end
  // ****************************************
  // data latches
  // ****************************************
  logic [DW-1:0] rd_lat;
  logic [DW-1:0] wr_lat;
  apb_latch #(.W(DW)) read_path_latch (
    .i_ref_clk(i_ref_clk),
    .i_rst    (i_rst),
    .i_data   (i_per_data),
    .i_capture(lat_d.capture),
    .i_hold   (ack_timing_stage),
    .o_data   (rd_lat)
  );
  apb_latch #(.W(DW)) write_path_latch (
    .i_ref_clk(i_ref_clk),
    .i_rst    (i_rst),
    .i_data   (i_cpu_data),
    .i_capture(lat_d.capture),
    .i_hold   (ack_timing_stage),
    .o_data   (wr_lat)
  );
  assign o_cpu_data    = rd_lat;
  assign o_cpu_data_oe = lat_q.rd_oe;
  assign o_per_data    = wr_lat;
  assign o_per_data_oe = lat_q.wr_oe;
  assign o_peripheral_chip_select_n = cs_n_q;
  // open drain: only ever pulls low
  assign o_dtack_n  = 1'b0;
  assign o_dtack_oe = dtack_oe_q;
  // ****************************************
  // checks
  // ****************************************
  idle_release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == APB_IDLE) |=> !o_dtack_oe || state_q != APB_IDLE)
    else $error("acknowledge driven while idle");
  read_steer_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    read_acc |=> o_cpu_data_oe && !o_per_data_oe)
    else $error("read latch steering wrong");
  cs_exclusive_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !(o_dtack_oe && !o_peripheral_chip_select_n))
    else $error("chip select with acknowledge");
  sel_on_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(select_timing_stage) |-> $past(e_fall))
    else $error("select stage set off edge");
  ack_on_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_dtack_oe) |-> $past(e_fall) && $past(select_timing_stage))
    else $error("ack not on next fall");
  cs_follows_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    select_timing_stage |=> !o_peripheral_chip_select_n || !select_timing_stage)
    else $error("chip select not timed");
  ds_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q != APB_IDLE && !ds_any) |=> state_q == APB_IDLE ##1 !o_dtack_oe)
    else $error("strobe negation did not clear");
  reset_idle_a: assert property (@(posedge i_ref_clk)
    i_rst |=> o_peripheral_chip_select_n && !o_dtack_oe)
    else $error("reset did not release");
  write_steer_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (peripheral_decode_select && !abus_syn[AW]) |=> o_per_data_oe && !o_cpu_data_oe)
    else $error("write latch steering wrong");
  idle_steer_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !peripheral_decode_select |=> o_per_data_oe && !o_cpu_data_oe)
    else $error("idle latch steering wrong");
  cs_decoded_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(o_peripheral_chip_select_n) |-> $past(peripheral_decode_select && ds_any && e_fall))
    else $error("chip select without decode");
  ack_held_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_dtack_oe && ds_any) |=> o_dtack_oe)
    else $error("acknowledge dropped early");
  cs_drop_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_dtack_oe) |-> o_peripheral_chip_select_n && !$past(o_peripheral_chip_select_n))
    else $error("chip select not dropped by ack");
  ack_access_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_dtack_oe |-> $past(ds_any))
    else $error("acknowledge outside an access");
  no_skip_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == APB_IDLE) |=> state_q != APB_ACK)
    else $error("select stage skipped");
  abandon_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (select_timing_stage && !ds_any) |=> o_peripheral_chip_select_n && !o_dtack_oe)
    else $error("abandoned access not cleared");
  edge_only_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_d != state_q && state_d != APB_IDLE) |-> e_fall)
    else $error("stage advanced off an e fall");
  capture_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    lat_d.capture |=> o_dtack_oe)
    else $error("capture without acknowledge");
  reset_steer_a: assert property (@(posedge i_ref_clk)
    i_rst |=> o_per_data_oe && !o_cpu_data_oe)
    else $error("reset latch steering wrong");
  reset_stage_a: assert property (@(posedge i_ref_clk)
    i_rst |=> !select_timing_stage && !ack_timing_stage)
    else $error("reset left a stage set");
  // ****************************************
  // data path checks
  // ****************************************
  data_frozen_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_dtack_oe && $past(o_dtack_oe)) |-> $stable(o_cpu_data) && $stable(o_per_data))
    else $error("latched data moved during ack");
  capture_value_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_dtack_oe) |-> o_cpu_data == $past(i_per_data) && o_per_data == $past(i_cpu_data))
    else $error("wrong data captured");
  rd_transparent_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == APB_IDLE) |=> o_cpu_data == $past(i_per_data))
    else $error("read latch not transparent");
  wr_transparent_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == APB_IDLE) |=> o_per_data == $past(i_cpu_data))
    else $error("write latch not transparent");
  // ****************************************
  // cover points
  // ****************************************
  ack_cover: cover property (@(posedge i_ref_clk) disable iff (i_rst) $rose(o_dtack_oe));
  read_cover: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_dtack_oe && o_cpu_data_oe);
  write_cover: cover property (@(posedge i_ref_clk) disable iff (i_rst) o_dtack_oe && o_per_data_oe);
  abandon_cover: cover property (@(posedge i_ref_clk) disable iff (i_rst) select_timing_stage && !ds_any);
  miss_cover: cover property (@(posedge i_ref_clk) disable iff (i_rst) stb.as && ds_any && !peripheral_decode_select);
endmodule
`default_nettype wire

// ==== tb/apb_cpu_model.sv ====
// processor bus master model facing the bridge
`timescale 1ns/1ps
`default_nettype none
module apb_cpu_model (
  // clock
  input  wire logic        i_ref_clk,
  // bridge answers
  input  wire logic        i_dtack_oe,
  input  wire logic [7:0]  i_cpu_data,
  input  wire logic [7:0]  i_per_data,
  input  wire logic        i_cpu_oe,
  input  wire logic        i_per_oe,
  input  wire logic        i_cs_n,
  // bus requests
  output logic             o_as_n,
  output logic             o_uds_n,
  output logic             o_lds_n,
  output logic             o_rw,
  output logic [22:0]      o_addr,
  output logic [7:0]       o_data
);
  initial begin
    o_as_n = 1'b1;
    {o_uds_n, o_lds_n} = 2'h3;
    o_rw = 1'b1;
    o_addr = 23'h0;
    o_data = 8'h0;
  end
  // ********************
  // one access
  // ********************
  // st: released, oe pair, cs high at ack, cs seen low, ack
  task automatic access(input logic rw, input logic [22:0] a, input logic [7:0] d,
                        input logic [1:0] ds, output logic [7:0] q, output logic [5:0] st, output int n);
    st = 6'h0;
    q = 8'h0;
    n = 0;
    @(posedge i_ref_clk);
    #1;
    o_as_n = 1'b0;
    {o_uds_n, o_lds_n} = ~ds;
    o_rw = rw;
    o_addr = a;
    o_data = rw ? ~o_data : d;
    // everything held until ack seen or 60 cycles pass
    while (n < 60 && st[0] !== 1'b1) begin
      @(posedge i_ref_clk);
      #1;
      n++;
      if (i_cs_n === 1'b0) st[1] = 1'b1;
      if (i_dtack_oe === 1'b1) begin
        st[0] = 1'b1;
        st[2] = i_cs_n;
        st[4:3] = {i_cpu_oe, i_per_oe};
        q = rw ? i_cpu_data : i_per_data;
      end
    end
    // released lines show the inverse, not the old value
    o_as_n = 1'b1;
    {o_uds_n, o_lds_n} = 2'h3;
    o_addr = ~a;
    o_data = ~o_data;
    repeat (6) @(posedge i_ref_clk);
    #1;
    st[5] = (i_dtack_oe === 1'b0 && i_cs_n === 1'b1);
  endtask
  // strobes dropped while the select stage stands: no acknowledge may follow
  // st: released, cs seen low, ack seen
  task automatic abandon(input logic [22:0] a, output logic [2:0] st);
    int n;
    st = 3'h0;
    n = 0;
    @(posedge i_ref_clk);
    #1;
    o_as_n = 1'b0;
    {o_uds_n, o_lds_n} = 2'h0;
    o_rw = 1'b1;
    o_addr = a;
    while (n < 60 && st[1] !== 1'b1) begin
      @(posedge i_ref_clk);
      #1;
      n++;
      if (i_cs_n === 1'b0) st[1] = 1'b1;
      if (i_dtack_oe === 1'b1) st[0] = 1'b1;
    end
    o_as_n = 1'b1;
    {o_uds_n, o_lds_n} = 2'h3;
    o_addr = ~a;
    repeat (6) begin
      @(posedge i_ref_clk);
      #1;
      if (i_dtack_oe === 1'b1) st[0] = 1'b1;
    end
    st[2] = (i_dtack_oe === 1'b0 && i_cs_n === 1'b1);
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the peripheral access bridge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk;
  logic        rst;
  logic        e_clk;
  logic [7:0]  per_in;
  logic        as_n, uds_n, lds_n, rw, dtack_n, dtack_oe, cpu_oe, per_oe, cs_n;
  logic [22:0] addr;
  logic [7:0]  cpu_wr, cpu_rd, per_out;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  // ********************
  // clocks, reset, timeout
  // ********************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // peripheral clock: 20 ref cycles, phase unrelated
  initial begin
    e_clk = 1'b0;
    #37;
    forever #200 e_clk = ~e_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end
  apb_bridge dut_u (
    .i_ref_clk(clk), .i_rst(rst), .i_as_n(as_n), .i_uds_n(uds_n), .i_lds_n(lds_n),
    .i_rw(rw), .i_addr(addr), .i_cpu_data(cpu_wr), .o_cpu_data(cpu_rd), .o_cpu_data_oe(cpu_oe),
    .o_dtack_n(dtack_n), .o_dtack_oe(dtack_oe), .i_e_clk(e_clk), .i_per_data(per_in),
    .o_per_data(per_out), .o_per_data_oe(per_oe), .o_peripheral_chip_select_n(cs_n));
  apb_cpu_model cpu_u (
    .i_ref_clk(clk), .i_dtack_oe(dtack_oe), .i_cpu_data(cpu_rd), .i_per_data(per_out),
    .i_cpu_oe(cpu_oe), .i_per_oe(per_oe), .i_cs_n(cs_n), .o_as_n(as_n), .o_uds_n(uds_n),
    .o_lds_n(lds_n), .o_rw(rw), .o_addr(addr), .o_data(cpu_wr));
  // ********************
  // checks and scenarios
  // ********************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_idle();
    check({3'h0, cs_n, dtack_oe, per_oe, cpu_oe, dtack_n}, 8'h14);
  endtask
  // decoded access; read steers the read latch, write keeps the write latch
  task automatic t_access(input logic r, input logic [7:0] d, input logic [1:0] ds);
    logic [7:0] q;
    logic [5:0] st;
    int n;
    per_in = r ? d : ~d;
    cpu_u.access(r, 23'h7F_0040, d, ds, q, st, n);
    check({2'h0, st}, {2'h0, 1'b1, r, ~r, 3'h7});
    check(q, d);
    check({7'h0, n > 20 && n < 50}, 8'h1);
    t_idle();
  endtask
  // address outside the window: no select, acknowledge never driven
  task automatic t_miss();
    logic [7:0] q;
    logic [5:0] st;
    int n;
    cpu_u.access(1'b1, 23'h7E_0040, 8'h00, 2'h3, q, st, n);
    check({2'h0, st}, 8'h20);
  endtask
  // strobes negated in the select stage: chip select returns high, no acknowledge
  task automatic t_abandon();
    logic [2:0] st;
    cpu_u.abandon(23'h7F_0010, st);
    check({5'h0, st}, 8'h06);
    t_idle();
  endtask
  initial begin
    rst = 1'b1;
    per_in = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    t_idle();
    for (int i = 1; i < 4; i++) begin
      t_access(1'b0, 8'hA5 ^ 8'(i), 2'(i));
      t_access(1'b1, 8'h3C ^ 8'(i), 2'(i));
    end
    t_miss();
    t_abandon();
    t_access(1'b0, 8'hFF, 2'h1);
    summarize();
  end
endmodule
`default_nettype wire
